// ==== verilog/alsbp_pkg.sv ====
/*
 * Shared constants and types for the angle load strobe/busy host port.
 * Assumes a 10 MHz ref_clk_i; all cycle counts derive from that period.
 */
package alsbp_pkg;

    localparam int ANGLE_W = 12;
    localparam int POLE_W = 4;
    localparam int ORDER_W = 8;
    localparam int CNT_W = 6;
    localparam int SYNC_STAGES = 2;

    localparam int CLK_PERIOD_NS = 100;

    // least time: round up, never below one cycle
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down, never below one cycle
    function automatic int cyc_floor(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int STROBE_MIN_NS = 100;
    localparam int GAP_MIN_NS = 2730;
    localparam int BUSY_RISE_NS = 30;
    localparam int BUSY_MIN_NS = 1700;
    localparam int BUSY_MAX_NS = 2500;

    localparam int STROBE_CYC = cyc_ceil(STROBE_MIN_NS);
    localparam int GAP_CYC = cyc_ceil(GAP_MIN_NS);
    localparam int BUSY_RISE_CYC = cyc_ceil(BUSY_RISE_NS);
    localparam int BUSY_MIN_CYC = cyc_ceil(BUSY_MIN_NS);
    localparam int BUSY_MAX_CYC = cyc_floor(BUSY_MAX_NS);
    localparam int RISE_TIMEOUT_CYC = BUSY_RISE_CYC + SYNC_STAGES + 2;

    localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
    localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_CYC);
    localparam logic [CNT_W-1:0] BUSY_MIN_CNT = CNT_W'(BUSY_MIN_CYC);
    localparam logic [CNT_W-1:0] BUSY_MAX_CNT = CNT_W'(BUSY_MAX_CYC);
    localparam logic [CNT_W-1:0] RISE_TIMEOUT_CNT = CNT_W'(RISE_TIMEOUT_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

    localparam logic [ANGLE_W-1:0] ANGLE_RESET = 12'h000;

    typedef struct packed {
        logic reverse;
        logic [POLE_W-1:0] pole_pairs;
        logic [ANGLE_W-1:0] angle;
    } alsbp_cmd_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_WAIT_BUSY,
        S_BUSY_HI
    } alsbp_state_t;

endpackage

// ==== verilog/alsbp_angle_shaper.sv ====
/*
 * Turns a requested angle into the word driven to the rotator:
 * optional negation and pole-pair scaling, all modulo one full turn.
 * Assumes pole_pairs is a power of two; other counts give no useful result.
 */
`timescale 1ns/1ps
module alsbp_angle_shaper (
    input wire alsbp_pkg::alsbp_cmd_t cmd_i,
    output logic [alsbp_pkg::ANGLE_W-1:0] angle_o
);
    logic [alsbp_pkg::ANGLE_W-1:0] signed_angle;
    logic [alsbp_pkg::POLE_W-1:0] shift;

    always_comb begin
        // negated angle rotates the other way, wraps mod 4096
        signed_angle = cmd_i.reverse ? (alsbp_pkg::ANGLE_RESET - cmd_i.angle)
                                     : cmd_i.angle;
        // times 2^(n-1) as a left shift, top bits dropped
        shift = (cmd_i.pole_pairs == 4'h0) ? 4'h0 : cmd_i.pole_pairs - 4'h1;
        angle_o = signed_angle << shift;
    end
endmodule

// ==== verilog/alsbp_host.sv ====
/*
 * Host end of the parallel angle port of a vector rotator: presents the
 * angle word, pulses the load strobe and supervises the busy answer.
 * Assumes busy_i and imbalance_flag_i are asynchronous pins; all user
 * inputs come from logic on ref_clk_i.
 */
`timescale 1ns/1ps
// Summary of operation
// - The strobe is held high for at least 100 ns per load.
// - At least 2.73 us pass from a strobe fall to the next strobe rise.
// - Reverse rotation is obtained by driving the negated angle.
// - In harmonic mode the angle advances 4096 steps per cycle of the chosen harmonic.
// - For power-of-two pole pairs the angle is shifted left by pole pairs minus one.
// - The word is valid around the strobe rising edge and the falling edge starts conversion.
module alsbp_host (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire alsbp_pkg::alsbp_cmd_t req_cmd_i,
    input wire logic harmonic_i,
    input wire logic fund_tick_i,
    input wire logic [alsbp_pkg::ORDER_W-1:0] harmonic_order_i,
    input wire logic busy_i,
    input wire logic imbalance_flag_i,
    output logic [alsbp_pkg::ANGLE_W-1:0] angle_o,
    output logic strobe_o,
    output logic req_ready_o,
    output logic load_done_o,
    output logic busy_fault_o,
    output logic imbalance_flag_o
);
    alsbp_pkg::alsbp_state_t state;
    logic [alsbp_pkg::CNT_W-1:0] cnt;
    logic [alsbp_pkg::CNT_W-1:0] gap;
    logic busy_meta;
    logic busy_s;
    logic imb_meta;
    logic imb_s;
    logic can_load;
    logic pend;
    logic [alsbp_pkg::ANGLE_W-1:0] phase;
    logic launch_usr;
    logic launch_hrm;
    logic launch;
    logic strobe_end;
    alsbp_pkg::alsbp_cmd_t sel_cmd;
    logic [alsbp_pkg::ANGLE_W-1:0] shaped;

    assign launch_usr = req_ready_o & req_valid_i;
    assign launch_hrm = can_load & harmonic_i & pend;
    assign launch = (state == alsbp_pkg::S_IDLE) & (launch_usr | launch_hrm);
    assign strobe_end = (state == alsbp_pkg::S_STROBE) && (cnt >= alsbp_pkg::STROBE_CNT);

    always_comb begin
        sel_cmd = req_cmd_i;
        if (harmonic_i) begin
            sel_cmd.angle = phase;
        end
    end

    alsbp_angle_shaper u_shaper (
        .cmd_i(sel_cmd),
        .angle_o(shaped)
    );

    // pins are asynchronous: two stages before anything looks at them
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_meta <= 1'b0;
            busy_s <= 1'b0;
            imb_meta <= 1'b0;
            imb_s <= 1'b0;
            imbalance_flag_o <= 1'b0;
        end else begin
            busy_meta <= busy_i;
            busy_s <= busy_meta;
            imb_meta <= imbalance_flag_i;
            imb_s <= imb_meta;
            imbalance_flag_o <= imb_s;
        end
    end

    // harmonic phase: order steps per fundamental tick, 4096 ticks per cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= alsbp_pkg::ANGLE_RESET;
            pend <= 1'b0;
        end else begin
            if (harmonic_i && fund_tick_i) begin
                phase <= phase + alsbp_pkg::ANGLE_W'(harmonic_order_i);
            end
            // a tick in the launch cycle stays pending; updates coalesce
            if (harmonic_i && fund_tick_i) begin
                pend <= 1'b1;
            end else if (launch_hrm && state == alsbp_pkg::S_IDLE) begin
                pend <= 1'b0;
            end
        end
    end

    // spacing between one strobe fall and the next rise
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap <= alsbp_pkg::CNT_ZERO;
        end else if (strobe_end) begin
            gap <= alsbp_pkg::GAP_CNT;
        end else if (gap != alsbp_pkg::CNT_ZERO) begin
            gap <= gap - alsbp_pkg::CNT_ONE;
        end
    end

    // readiness lags a cycle, so a stale busy glitch costs one cycle only
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            can_load <= 1'b0;
            req_ready_o <= 1'b0;
        end else if (launch) begin
            can_load <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            can_load <= (state == alsbp_pkg::S_IDLE) && (gap == alsbp_pkg::CNT_ZERO)
                        && !busy_s;
            req_ready_o <= (state == alsbp_pkg::S_IDLE) && (gap == alsbp_pkg::CNT_ZERO)
                           && !busy_s && !harmonic_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= alsbp_pkg::S_IDLE;
            cnt <= alsbp_pkg::CNT_ZERO;
            angle_o <= alsbp_pkg::ANGLE_RESET;
            strobe_o <= 1'b0;
            load_done_o <= 1'b0;
            busy_fault_o <= 1'b0;
        end else begin
            load_done_o <= 1'b0;
            case (state)
                alsbp_pkg::S_IDLE: begin
                    if (launch) begin
                        // word goes out a cycle ahead of the rising edge
                        angle_o <= shaped;
                        busy_fault_o <= 1'b0;
                        state <= alsbp_pkg::S_SETUP;
                    end
                end
                alsbp_pkg::S_SETUP: begin
                    strobe_o <= 1'b1;
                    cnt <= alsbp_pkg::CNT_ONE;
                    state <= alsbp_pkg::S_STROBE;
                end
                alsbp_pkg::S_STROBE: begin
                    if (strobe_end) begin
                        strobe_o <= 1'b0;
                        cnt <= alsbp_pkg::CNT_ONE;
                        state <= alsbp_pkg::S_WAIT_BUSY;
                    end else begin
                        cnt <= cnt + alsbp_pkg::CNT_ONE;
                    end
                end
                alsbp_pkg::S_WAIT_BUSY: begin
                    if (busy_s) begin
                        cnt <= alsbp_pkg::CNT_ONE;
                        state <= alsbp_pkg::S_BUSY_HI;
                    end else if (cnt >= alsbp_pkg::RISE_TIMEOUT_CNT) begin
                        busy_fault_o <= 1'b1;
                        state <= alsbp_pkg::S_IDLE;
                    end else begin
                        cnt <= cnt + alsbp_pkg::CNT_ONE;
                    end
                end
                alsbp_pkg::S_BUSY_HI: begin
                    if (!busy_s) begin
                        busy_fault_o <= (cnt < alsbp_pkg::BUSY_MIN_CNT);
                        load_done_o <= 1'b1;
                        state <= alsbp_pkg::S_IDLE;
                    end else if (cnt >= alsbp_pkg::BUSY_MAX_CNT) begin
                        // stuck busy: give up; the busy_s check blocks reload
                        busy_fault_o <= 1'b1;
                        state <= alsbp_pkg::S_IDLE;
                    end else begin
                        cnt <= cnt + alsbp_pkg::CNT_ONE;
                    end
                end
                default: begin
                    state <= alsbp_pkg::S_IDLE;
                end
            endcase
        end
    end

    // helper counters read only by the checks below
    logic [alsbp_pkg::CNT_W-1:0] lo_cnt;
    logic [alsbp_pkg::CNT_W-1:0] hi_cnt;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lo_cnt <= alsbp_pkg::CNT_MAX;
            hi_cnt <= alsbp_pkg::CNT_ZERO;
        end else begin
            lo_cnt <= strobe_o ? alsbp_pkg::CNT_ZERO
                    : (lo_cnt == alsbp_pkg::CNT_MAX ? lo_cnt : lo_cnt + alsbp_pkg::CNT_ONE);
            hi_cnt <= !strobe_o ? alsbp_pkg::CNT_ZERO
                    : (hi_cnt == alsbp_pkg::CNT_MAX ? hi_cnt : hi_cnt + alsbp_pkg::CNT_ONE);
        end
    end

    AST_STROBE_WIDTH: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(strobe_o) |-> hi_cnt >= alsbp_pkg::STROBE_CNT)
        else $error("strobe high time too short");

    AST_STROBE_GAP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(strobe_o) |-> lo_cnt >= alsbp_pkg::GAP_CNT)
        else $error("strobe rose too soon after previous fall");

    AST_WORD_SETUP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(strobe_o) |-> $stable(angle_o) ##1 $stable(angle_o))
        else $error("angle word moved around strobe rise");

    AST_NO_LOAD_BUSY: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (busy_s && state == alsbp_pkg::S_IDLE) |=> state == alsbp_pkg::S_IDLE)
        else $error("load started while busy high");

    AST_BUSY_STUCK: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (state == alsbp_pkg::S_BUSY_HI && busy_s && cnt >= alsbp_pkg::BUSY_MAX_CNT)
        |=> busy_fault_o && state == alsbp_pkg::S_IDLE)
        else $error("overlong busy not flagged");

    AST_REVERSE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (launch && !harmonic_i && req_cmd_i.reverse && req_cmd_i.pole_pairs == 4'h1)
        |=> angle_o == alsbp_pkg::ANGLE_RESET - $past(req_cmd_i.angle))
        else $error("reverse angle not negated");

    AST_POLE_SHIFT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (launch && !harmonic_i && !req_cmd_i.reverse && req_cmd_i.pole_pairs == 4'h2)
        |=> angle_o == ($past(req_cmd_i.angle) << 1))
        else $error("pole pair shift wrong");

    AST_HARM_STEP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (harmonic_i && fund_tick_i)
        |=> phase == $past(phase) + alsbp_pkg::ANGLE_W'($past(harmonic_order_i)))
        else $error("harmonic phase step wrong");

    AST_IMB_PATH: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(imbalance_flag_i) ##1 imbalance_flag_i[*2] |=> imbalance_flag_o)
        else $error("imbalance flag not forwarded");

    AST_BUSY_RISE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(strobe_o) |-> ##[1:8] (state != alsbp_pkg::S_WAIT_BUSY
        && (busy_fault_o || state == alsbp_pkg::S_BUSY_HI)))
        else $error("busy wait not bounded");
endmodule

// ==== verif/alsbp_rotator_model.sv ====
/*
 * Behavioural model of the vector rotator's digital angle port.
 * Assumes strobe_i and angle_i come from the host under test.
 */
`timescale 1ns/1ps
module alsbp_rotator_model (
    input wire logic strobe_i,
    input wire logic [11:0] angle_i,
    input wire logic busy_en_i,
    input var int busy_ns_i,
    input var int phase_sum_mv_i,
    output logic busy_o,
    output logic imbalance_flag_o,
    output logic [11:0] latched_o,
    output logic [11:0] applied_o,
    output int viol_cnt_o
);
    localparam int THRESH_MV = 500;
    realtime t_rise = -1.0e6;
    realtime t_fall = -1.0e6;
    realtime t_word = -1.0e6;
    logic armed = 1'b0;
    initial begin
        busy_o = 1'b0;
        latched_o = 12'h000;
        applied_o = 12'h000;
        viol_cnt_o = 0;
    end
    assign imbalance_flag_o = (phase_sum_mv_i > 3 * THRESH_MV);
    always @(angle_i) begin
        if ($realtime - t_rise < 25.0) viol_cnt_o++;
        t_word = $realtime;
    end
    always @(posedge strobe_i) begin
        if ($realtime - t_word < 25.0) viol_cnt_o++;
        if ($realtime - t_fall < 2730.0) viol_cnt_o++;
        t_rise = $realtime;
        armed = 1'b1;
        latched_o = angle_i;
    end
    // armed keeps the x-to-0 settle at reset from starting a conversion
    always @(negedge strobe_i) begin
        if (armed) begin
            armed = 1'b0;
            t_fall = $realtime;
            if (t_fall - t_rise < 100.0) viol_cnt_o++;
            if (busy_en_i && !busy_o) fork
                begin
                    #30 busy_o = 1'b1;
                    #(busy_ns_i) busy_o = 1'b0;
                    applied_o = latched_o;
                end
            join_none
        end
    end
endmodule

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the angle host port against the rotator model.
 * Assumes the 10 MHz clock and the hand-over timing of the host.
 */
`timescale 1ns/1ps
module tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic harmonic_i = 1'b0;
    logic fund_tick_i = 1'b0;
    logic busy_en = 1'b1;
    logic busy_i, imb, strobe_o, req_ready_o, load_done_o, busy_fault_o, imbalance_flag_o;
    alsbp_pkg::alsbp_cmd_t req_cmd_i = '0;
    logic [7:0] order = 8'h00;
    logic [11:0] angle_o, lat, app;
    int busy_ns = 2000;
    int sum_mv = 0;
    int viol, cyc = 0;
    int error_cnt = 0;
    int checks = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    alsbp_host alsbp_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_cmd_i(req_cmd_i), .harmonic_i(harmonic_i), .fund_tick_i(fund_tick_i),
        .harmonic_order_i(order), .busy_i(busy_i), .imbalance_flag_i(imb), .angle_o(angle_o),
        .strobe_o(strobe_o), .req_ready_o(req_ready_o), .load_done_o(load_done_o),
        .busy_fault_o(busy_fault_o), .imbalance_flag_o(imbalance_flag_o));
    alsbp_rotator_model alsbp_rotator_model_inst (.strobe_i(strobe_o), .angle_i(angle_o),
        .busy_en_i(busy_en), .busy_ns_i(busy_ns), .phase_sum_mv_i(sum_mv), .busy_o(busy_i),
        .imbalance_flag_o(imb), .latched_o(lat), .applied_o(app), .viol_cnt_o(viol));
    task automatic conclude;
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string name, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // independent reference: negate, then shift by pole pairs minus one
    function automatic logic [11:0] shape(input alsbp_pkg::alsbp_cmd_t c);
        logic [11:0] v;
        v = c.reverse ? 12'(12'h000 - c.angle) : c.angle;
        return (c.pole_pairs == 4'h0) ? v : 12'(v << (c.pole_pairs - 4'h1));
    endfunction
    task automatic load(input alsbp_pkg::alsbp_cmd_t c, input logic fault);
        int n;
        logic done;
        done = 1'b0;
        @(negedge ref_clk_i);
        req_cmd_i = c;
        req_valid_i = 1'b1;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 300) begin
            @(negedge ref_clk_i);
            n++;
        end
        cmp("ready wait", 12'h000, {11'h000, n >= 300});
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 300) begin
            @(negedge ref_clk_i);
            n++;
            if (load_done_o === 1'b1) done = 1'b1;
        end
        cmp("ready return", 12'h000, {11'h000, n >= 300});
        cmp("angle_o", shape(c), angle_o);
        cmp("latched", shape(c), lat);
        cmp("busy_fault_o", {11'h000, fault}, {11'h000, busy_fault_o});
        if (!fault) begin
            cmp("load_done_o", 12'h001, {11'h000, done});
            cmp("applied", shape(c), app);
        end
    endtask
    task automatic t_reset;
        repeat (5) @(negedge ref_clk_i);
        cmp("reset angle_o", 12'h000, angle_o);
        cmp("reset strobe_o", 12'h000, {11'h000, strobe_o});
        cmp("reset req_ready_o", 12'h000, {11'h000, req_ready_o});
        rst_i = 1'b0;
    endtask
    task automatic t_reverse;
        load({1'b0, 4'h1, 12'h123}, 1'b0);
        load({1'b1, 4'h1, 12'h001}, 1'b0);
        load({1'b1, 4'h0, 12'h000}, 1'b0);
        load({1'b1, 4'h1, 12'h800}, 1'b0);
    endtask
    // loads run back to back, so the model sees the shortest host spacing plus one cycle
    task automatic t_poles;
        for (int i = 0; i < 4; i++) load({1'b0, 4'(1 << i), 12'hABC}, 1'b0);
        load({1'b1, 4'h2, 12'h7FF}, 1'b0);
    endtask
    task automatic t_busy;
        int w[5] = '{1000, 1800, 2400, 4000, 0};
        for (int i = 0; i < 5; i++) begin
            busy_ns = w[i];
            busy_en = (w[i] != 0);
            load({1'b0, 4'h1, 12'(i + 5)}, (w[i] < 1700 || w[i] > 2500));
        end
        busy_ns = 2000;
        busy_en = 1'b1;
        load({1'b0, 4'h1, 12'hFFF}, 1'b0);
    endtask
    task automatic t_harm;
        int n;
        @(negedge ref_clk_i);
        harmonic_i = 1'b1;
        order = 8'h03;
        req_cmd_i = {1'b0, 4'h1, 12'h000};
        for (int k = 0; k < 4; k++) begin
            @(negedge ref_clk_i);
            fund_tick_i = 1'b1;
            @(negedge ref_clk_i);
            fund_tick_i = 1'b0;
            n = 0;
            while (load_done_o !== 1'b1 && n < 200) begin
                @(negedge ref_clk_i);
                n++;
            end
            cmp("harmonic wait", 12'h000, {11'h000, n >= 200});
            repeat (12) @(negedge ref_clk_i);
            // phase starts at zero and gains the order, 3, on every tick
            cmp("harmonic step", 12'(3 * (k + 1)), app);
        end
        harmonic_i = 1'b0;
    endtask
    task automatic t_imb;
        @(negedge ref_clk_i);
        sum_mv = 1400;
        repeat (5) @(negedge ref_clk_i);
        cmp("imbalance low", 12'h000, {11'h000, imbalance_flag_o});
        sum_mv = 1600;
        repeat (5) @(negedge ref_clk_i);
        cmp("imbalance high", 12'h001, {11'h000, imbalance_flag_o});
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        t_reset();
        t_reverse();
        t_poles();
        t_busy();
        t_harm();
        t_imb();
        cmp("port violations", 12'h000, 12'(viol));
        conclude();
    end
endmodule
